// [logic/bdfc_pkg.sv]
// Shared constants and types for the buck scaling and fault control block
package bdfc_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASE_DELAY_NS = 100;
  // Least time, so round up to whole cycles
  localparam int PHASE_DELAY_CYC = (PHASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_FREQ_KHZ = 2250;
  localparam int RESTART_MS = 100;
  // Restart delay counted in full-rate switching cycles
  localparam int RESTART_CYC = RESTART_MS * SW_FREQ_KHZ;
  localparam int RATE_ACC_W = 16;
  localparam logic [15:0] RATE_INC = 16'((SW_FREQ_KHZ * 65536) / (CLK_MHZ * 1000));
  localparam logic [4:0] OC_RUN_LEN = 5'h10;
  localparam int RESTART_W = 18;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CL_STATUS = 8'h01;
  localparam logic [7:0] REG_UV_STATUS = 8'h02;
  localparam logic [7:0] REG_MASK_RATE = 8'h03;
  localparam logic [7:0] REG_PHASE = 8'h04;
  localparam logic [7:0] REG_NORMAL_BASE = 8'h10;
  localparam logic [7:0] REG_SCALED_BASE = 8'h14;
  localparam logic [7:0] REG_TARGET_BASE = 8'h18;

  // Control register fields
  localparam int CTRL_POL = 0;
  localparam int CTRL_SCALE_EN = 1;
  localparam int CTRL_RAMP_LO = 2;
  localparam int CTRL_IRQ_UNMASK = 4;
  localparam int CTRL_UV_UNMASK = 5;
  localparam int CTRL_BYP_OC_MASK = 6;
  localparam int CTRL_R1_GOOD_MASK = 7;

  // Status register fields
  localparam int UV_LATCH = 0;
  localparam int UV_FAULT_STATE = 1;
  localparam int UV_BYPASS = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam logic [7:0] MASK_RATE_RST = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] NORMAL_RST = 8'h80;
  localparam logic [7:0] SCALED_RST = 8'h60;

  // Synchronised pin vector layout
  localparam int PIN_MODE = 0;
  localparam int PIN_UVLO = 1;
  localparam int PIN_EXT = 2;
  localparam int PIN_LIMIT = 3;
  localparam int PIN_SHORT = 7;
  localparam int PIN_BYP3 = 11;
  localparam int PIN_BYP6 = 12;
  localparam int PIN_GOOD = 13;
  localparam int PIN_OVER = 17;
  localparam int PIN_SS = 21;
  localparam int PIN_W = 22;

  typedef enum logic [1:0] {
    BDFC_RUN = 2'b01,
    BDFC_FAULT = 2'b10
  } bdfc_state_t;
endpackage

// [logic/bdfc_rate_gen.sv]
// Switching clock edge generator: fractional divider giving rise and fall pulses
module bdfc_rate_gen (
  input wire logic mclk,
  input wire logic arst_n,
  output logic sw_rise,
  output logic sw_fall
);
  typedef struct packed {
    logic [bdfc_pkg::RATE_ACC_W-1:0] acc;
    logic rise;
    logic fall;
  } bdfc_rate_t;

  bdfc_rate_t s;
  bdfc_rate_t next_s;

  // Phase accumulator; its top bit is the switching clock, so jitter is one mclk
  always_comb begin
    next_s = s;
    next_s.acc = s.acc + bdfc_pkg::RATE_INC;
    next_s.rise = ~s.acc[bdfc_pkg::RATE_ACC_W-1] & next_s.acc[bdfc_pkg::RATE_ACC_W-1];
    next_s.fall = s.acc[bdfc_pkg::RATE_ACC_W-1] & ~next_s.acc[bdfc_pkg::RATE_ACC_W-1];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sw_rise = s.rise;
  assign sw_fall = s.fall;
endmodule

// [logic/bdfc_rail.sv]
// Per-rail switching timing: rate halving, edge choice, turn-on shift, overcurrent run
module bdfc_rail (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sw_rise,
  input wire logic sw_fall,
  input wire logic half_rate,
  input wire logic edge_fall,
  input wire logic delay_on,
  input wire logic gate_off,
  input wire logic at_limit,
  input wire logic limit_clear,
  output logic hs_on,
  output logic overcurrent
);
  localparam int DW = bdfc_pkg::PHASE_DELAY_CYC;

  typedef struct packed {
    logic tog;
    logic [DW-1:0] dly;
    logic [4:0] run_cnt;
    logic hs_on;
    logic overcurrent;
  } bdfc_rail_t;

  bdfc_rail_t s;
  bdfc_rail_t next_s;

  always_comb begin
    logic rise_sel;
    logic fall_sel;
    logic edge_sel;
    rise_sel = 1'b0;
    fall_sel = 1'b0;
    edge_sel = 1'b0;
    next_s = s;
    next_s.hs_on = 1'b0;
    next_s.overcurrent = 1'b0;
    rise_sel = half_rate ? (sw_rise & ~s.tog) : sw_rise;
    fall_sel = half_rate ? (sw_rise & s.tog) : sw_fall;
    if (sw_rise) begin
      next_s.tog = ~s.tog;
    end
    edge_sel = edge_fall ? fall_sel : rise_sel;
    next_s.dly = {s.dly[DW-2:0], edge_sel & delay_on};
    next_s.hs_on = ~gate_off & (delay_on ? s.dly[DW-1] : edge_sel);
    if (limit_clear) begin
      next_s.run_cnt = 5'h00;
    end else if (rise_sel) begin
      if (!at_limit) begin
        next_s.run_cnt = 5'h00;
      end else if (s.run_cnt != bdfc_pkg::OC_RUN_LEN) begin
        next_s.run_cnt = s.run_cnt + 5'h01;
        next_s.overcurrent = (s.run_cnt + 5'h01) == bdfc_pkg::OC_RUN_LEN;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hs_on = s.hs_on;
  assign overcurrent = s.overcurrent;
endmodule

// [logic/bdfc_top.sv]
// Buck scaling, switching alignment and fault control with a plain register port
// Functional notes
// - target normal value, scaled value while scaling
// - ramp between targets at selected rate
// - hide good, overvolt, limit flags while ramping
// - turn-on shift delays high side 100 ns
// - edge select picks rising or falling edge
// - sixteen cycles at limit pull interrupt low
// - short shuts all rails, restarts after 100 ms
// - limit status latched until host reads
// - fault mask stops rail overcurrent faults
// - half rate select halves switching frequency
// - bypass keeps low side off, switch on
// - bypass good follows soft start done
// - bypass 3A detector latches status bit zero
// - bypass 6A shuts down, latches, restarts later
// - bypass disables rail one overvolt flag
// - mode pin sampled once at lockout release
// - enable pin polarity set by polarity bit
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
module bdfc_top #(
  parameter int unsigned RESTART_CYCLES = bdfc_pkg::RESTART_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mode_pin,
  input wire logic uvlo_ok,
  input wire logic external_enable_pin,
  input wire logic [3:0] peak_at_limit,
  input wire logic [3:0] peak_short,
  input wire logic bypass_oc_detect,
  input wire logic bypass_shutdown_detect,
  input wire logic [3:0] rail_good_raw,
  input wire logic [3:0] rail_overvolt_raw,
  input wire logic softstart_done,
  output logic [31:0] voltage_target,
  output logic [3:0] rail_enable,
  output logic [3:0] high_side_on,
  output logic [3:0] low_side_enable,
  output logic bypass_switch_on,
  output logic bypass_mode,
  output logic [3:0] power_ok_flag,
  output logic [3:0] overvoltage_flag,
  output logic [3:0] current_limit_flag,
  output logic main_reset_out_n,
  output logic irq_n,
  output logic supply_fault_state
);
  typedef struct packed {
    logic [bdfc_pkg::PIN_W-1:0] sync1;
    logic [bdfc_pkg::PIN_W-1:0] sync2;
    logic mode_taken;
    logic uvlo_prev;
    logic bypass;
    logic [7:0] ctrl;
    logic [7:0] mask_rate;
    logic [7:0] phase;
    logic [3:0][7:0] normal;
    logic [3:0][7:0] scaled;
    logic [3:0][7:0] target;
    logic [3:0] cl_status;
    logic uv_status;
    bdfc_pkg::bdfc_state_t state;
    logic [bdfc_pkg::RESTART_W-1:0] restart_cnt;
    logic [2:0] ramp_cnt;
    logic [7:0] rdata;
    logic [3:0] rail_en;
    logic [3:0] ls_en;
    logic byp_on;
    logic [3:0] pok;
    logic [3:0] ovf;
    logic [3:0] clf;
    logic rst_n;
    logic irq_n;
  } bdfc_core_t;

  bdfc_core_t s;
  bdfc_core_t next_s;
  logic sw_rise;
  logic sw_fall;
  logic [3:0] oc_evt;
  logic [bdfc_pkg::PIN_W-1:0] pins_in;

  // Raw pin vector, every bit is asynchronous to mclk
  assign pins_in = {softstart_done, rail_overvolt_raw, rail_good_raw, bypass_shutdown_detect,
                    bypass_oc_detect, peak_short, peak_at_limit, external_enable_pin,
                    uvlo_ok, mode_pin};

  bdfc_rate_gen u_rate (
    .mclk(mclk),
    .arst_n(arst_n),
    .sw_rise(sw_rise),
    .sw_fall(sw_fall)
  );

  // One timing slice per rail; rail one is gated while it is a bypass switch
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_rail
      bdfc_rail u_rail (
        .mclk(mclk),
        .arst_n(arst_n),
        .sw_rise(sw_rise),
        .sw_fall(sw_fall),
        .half_rate(s.mask_rate[4 + g]),
        .edge_fall(s.phase[4 + g]),
        .delay_on(s.phase[g]),
        .gate_off(~s.rail_en[g] | (s.bypass & (g == 0))),
        .at_limit(s.sync2[bdfc_pkg::PIN_LIMIT + g]),
        .limit_clear(s.state == bdfc_pkg::BDFC_FAULT),
        .hs_on(high_side_on[g]),
        .overcurrent(oc_evt[g])
      );
    end
  endgenerate

  // Whole next-state computation
  always_comb begin
    logic [bdfc_pkg::PIN_W-1:0] p;
    logic ext_active;
    logic scaling;
    logic busy;
    logic ramp_step;
    logic [2:0] ramp_lim;
    logic [7:0] goal;
    logic [3:0] cl_set;
    logic [3:0] short_flt;
    logic byp_flt;
    logic fault_trig;
    logic [3:0] good_eff;
    logic [3:0] over_eff;
    logic [3:0] lim_eff;
    logic [7:0] rv;
    p = s.sync2;
    ext_active = 1'b0;
    scaling = 1'b0;
    busy = 1'b0;
    ramp_step = 1'b0;
    ramp_lim = 3'h0;
    goal = 8'h00;
    cl_set = 4'h0;
    short_flt = 4'h0;
    byp_flt = 1'b0;
    fault_trig = 1'b0;
    good_eff = 4'h0;
    over_eff = 4'h0;
    lim_eff = 4'h0;
    rv = 8'h00;
    next_s = s;

    // Two-stage synchroniser; only the second stage is read
    next_s.sync1 = pins_in;
    next_s.sync2 = s.sync1;

    // capture mode once at lockout release
    next_s.uvlo_prev = p[bdfc_pkg::PIN_UVLO];
    if (p[bdfc_pkg::PIN_UVLO] && !s.uvlo_prev && !s.mode_taken) begin
      next_s.mode_taken = 1'b1;
      next_s.bypass = p[bdfc_pkg::PIN_MODE];
    end

    ext_active = p[bdfc_pkg::PIN_EXT] ^ s.ctrl[bdfc_pkg::CTRL_POL];
    // scaling needs the bit and the pin
    scaling = s.ctrl[bdfc_pkg::CTRL_SCALE_EN] & ext_active;

    case (s.ctrl[bdfc_pkg::CTRL_RAMP_LO +: 2])
      2'h0: ramp_lim = 3'h0;
      2'h1: ramp_lim = 3'h1;
      2'h2: ramp_lim = 3'h3;
      default: ramp_lim = 3'h7;
    endcase
    ramp_step = sw_rise & (s.ramp_cnt >= ramp_lim);
    if (sw_rise) begin
      next_s.ramp_cnt = ramp_step ? 3'h0 : s.ramp_cnt + 3'h1;
    end

    for (int r = 0; r < 4; r++) begin
      // select target; steps up or down, so normal may sit above or below scaled
      goal = scaling ? s.scaled[r] : s.normal[r];
      if (s.target[r] != goal) begin
        busy = 1'b1;
        if (ramp_step) begin
          next_s.target[r] = (s.target[r] < goal) ? s.target[r] + 8'h01 : s.target[r] - 8'h01;
        end
      end
      if (s.bypass && r == 0) begin
        // bypass detector gated by its mask and unmask bits
        cl_set[r] = p[bdfc_pkg::PIN_BYP3] & ~s.ctrl[bdfc_pkg::CTRL_BYP_OC_MASK]
                    & s.ctrl[bdfc_pkg::CTRL_IRQ_UNMASK];
      end else begin
        short_flt[r] = p[bdfc_pkg::PIN_SHORT + r] & ~s.mask_rate[r];
        cl_set[r] = (oc_evt[r] | p[bdfc_pkg::PIN_SHORT + r]) & ~s.mask_rate[r];
      end
    end

    byp_flt = s.bypass & p[bdfc_pkg::PIN_BYP6] & s.ctrl[bdfc_pkg::CTRL_UV_UNMASK]
              & ~s.ctrl[bdfc_pkg::CTRL_R1_GOOD_MASK];
    fault_trig = (|short_flt) | byp_flt;

    // supply fault state and timed restart
    case (s.state)
      bdfc_pkg::BDFC_RUN: begin
        if (fault_trig) begin
          next_s.state = bdfc_pkg::BDFC_FAULT;
          next_s.restart_cnt = '0;
        end
      end
      bdfc_pkg::BDFC_FAULT: begin
        if (sw_rise) begin
          if (s.restart_cnt == bdfc_pkg::RESTART_W'(RESTART_CYCLES - 1)) begin
            next_s.state = bdfc_pkg::BDFC_RUN;
          end else begin
            next_s.restart_cnt = s.restart_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_s.state = bdfc_pkg::BDFC_FAULT;
        next_s.restart_cnt = '0;
      end
    endcase

    // all rails off while in the fault state
    next_s.rail_en = {4{(next_s.state == bdfc_pkg::BDFC_RUN) & s.mode_taken}};
    // bypass keeps low side off and switch held on
    next_s.ls_en = next_s.rail_en & {3'h7, ~s.bypass};
    next_s.byp_on = next_s.rail_en[0] & s.bypass;

    // rail one good follows soft start in bypass
    good_eff = p[bdfc_pkg::PIN_GOOD +: 4];
    if (s.bypass) begin
      good_eff[0] = s.byp_on & p[bdfc_pkg::PIN_SS];
    end
    // no overvolt report on the bypass switch
    over_eff = p[bdfc_pkg::PIN_OVER +: 4] & {3'h7, ~next_s.bypass};
    lim_eff = p[bdfc_pkg::PIN_LIMIT +: 4];
    if (s.bypass) begin
      lim_eff[0] = p[bdfc_pkg::PIN_BYP3];
    end
    // flags hidden during a target transition
    next_s.pok = busy ? 4'hF : good_eff;
    next_s.ovf = busy ? 4'h0 : over_eff;
    next_s.clf = busy ? 4'h0 : lim_eff;
    next_s.rst_n = (next_s.state == bdfc_pkg::BDFC_RUN) & (&next_s.pok) & ~(|next_s.ovf);

    // Register read; status clears on read but a new set wins
    if (reg_addr == bdfc_pkg::REG_CTRL) begin
      rv = s.ctrl;
    end else if (reg_addr == bdfc_pkg::REG_CL_STATUS) begin
      rv = {4'h0, s.cl_status};
    end else if (reg_addr == bdfc_pkg::REG_UV_STATUS) begin
      rv = {5'h00, s.bypass, s.state == bdfc_pkg::BDFC_FAULT, s.uv_status};
    end else if (reg_addr == bdfc_pkg::REG_MASK_RATE) begin
      rv = s.mask_rate;
    end else if (reg_addr == bdfc_pkg::REG_PHASE) begin
      rv = s.phase;
    end else if (reg_addr[7:2] == bdfc_pkg::REG_NORMAL_BASE[7:2]) begin
      rv = s.normal[reg_addr[1:0]];
    end else if (reg_addr[7:2] == bdfc_pkg::REG_SCALED_BASE[7:2]) begin
      rv = s.scaled[reg_addr[1:0]];
    end else if (reg_addr[7:2] == bdfc_pkg::REG_TARGET_BASE[7:2]) begin
      rv = s.target[reg_addr[1:0]];
    end
    next_s.rdata = reg_rd ? rv : 8'h00;

    // latched until read, set beats clear
    if (reg_rd && reg_addr == bdfc_pkg::REG_CL_STATUS) begin
      next_s.cl_status = cl_set;
    end else begin
      next_s.cl_status = s.cl_status | cl_set;
    end
    // shutdown latch in the undervolt status
    if (reg_rd && reg_addr == bdfc_pkg::REG_UV_STATUS) begin
      next_s.uv_status = byp_flt;
    end else begin
      next_s.uv_status = s.uv_status | byp_flt;
    end
    // interrupt low while any latched event stands
    next_s.irq_n = ~((|next_s.cl_status) | next_s.uv_status);

    // Register write
    if (reg_wr) begin
      if (reg_addr == bdfc_pkg::REG_CTRL) begin
        next_s.ctrl = reg_wdata;
      end else if (reg_addr == bdfc_pkg::REG_MASK_RATE) begin
        next_s.mask_rate = reg_wdata;
      end else if (reg_addr == bdfc_pkg::REG_PHASE) begin
        next_s.phase = reg_wdata;
      end else if (reg_addr[7:2] == bdfc_pkg::REG_NORMAL_BASE[7:2]) begin
        next_s.normal[reg_addr[1:0]] = reg_wdata;
      end else if (reg_addr[7:2] == bdfc_pkg::REG_SCALED_BASE[7:2]) begin
        next_s.scaled[reg_addr[1:0]] = reg_wdata;
      end
    end
  end

  // State register; rails start off, targets start at the normal setting
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.ctrl <= bdfc_pkg::CTRL_RST;
      s.mask_rate <= bdfc_pkg::MASK_RATE_RST;
      s.phase <= bdfc_pkg::PHASE_RST;
      s.normal <= {4{bdfc_pkg::NORMAL_RST}};
      s.scaled <= {4{bdfc_pkg::SCALED_RST}};
      s.target <= {4{bdfc_pkg::NORMAL_RST}};
      s.state <= bdfc_pkg::BDFC_RUN;
      s.pok <= 4'hF;
      s.rst_n <= 1'b0;
      s.irq_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = s.rdata;
  assign voltage_target = s.target;
  assign rail_enable = s.rail_en;
  assign low_side_enable = s.ls_en;
  assign bypass_switch_on = s.byp_on;
  assign bypass_mode = s.bypass;
  assign power_ok_flag = s.pok;
  assign overvoltage_flag = s.ovf;
  assign current_limit_flag = s.clf;
  assign main_reset_out_n = s.rst_n;
  assign irq_n = s.irq_n;
  assign supply_fault_state = s.state == bdfc_pkg::BDFC_FAULT;
endmodule

// [verification/bdfc_top_sva.sv]
// Port-level assertions for the buck scaling and fault control block
module bdfc_top_sva #(
  parameter int unsigned RESTART_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic softstart_done,
  input wire logic [3:0] rail_enable,
  input wire logic [3:0] high_side_on,
  input wire logic [3:0] low_side_enable,
  input wire logic bypass_switch_on,
  input wire logic bypass_mode,
  input wire logic [3:0] power_ok_flag,
  input wire logic [3:0] overvoltage_flag,
  input wire logic irq_n,
  input wire logic supply_fault_state
);
  int unsigned flt_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // Fault length counter; a huge bound would hide a stuck restart timer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flt_cnt <= 0;
    end else begin
      flt_cnt <= supply_fault_state ? flt_cnt + 1 : 0;
    end
  end
  // Shutdown picture and soft start run
  sequence shut_s;
    rail_enable == 4'h0 && !irq_n;
  endsequence
  sequence soft_s;
    (bypass_mode && softstart_done && !supply_fault_state) [*4];
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  fault_entry_a: assert property ($rose(supply_fault_state) |-> shut_s)
    else $error("fault without shutdown");
  fault_off_a: assert property (supply_fault_state |-> !bypass_switch_on && rail_enable == 4'h0)
    else $error("rail on during fault");
  fault_len_a: assert property (flt_cnt <= RESTART_CYCLES * 9 + 12)
    else $error("restart wait too long");
  bypass_low_a: assert property (bypass_mode |-> !low_side_enable[0])
    else $error("low side on in bypass");
  bypass_ov_a: assert property (bypass_mode |-> !overvoltage_flag[0])
    else $error("overvoltage flag in bypass");
  bypass_good_a: assert property (soft_s |-> power_ok_flag[0])
    else $error("rail one good low");
  mode_hold_a: assert property (bypass_mode |=> bypass_mode)
    else $error("captured mode changed");
  hs_space_a: assert property (high_side_on[0] |=> !high_side_on[0] [*7])
    else $error("turn-on pulses too close");
endmodule

bind bdfc_top bdfc_top_sva #(.RESTART_CYCLES(RESTART_CYCLES)) sva (.mclk, .arst_n, .reg_rd,
  .reg_rdata, .softstart_done, .rail_enable, .high_side_on, .low_side_enable, .bypass_switch_on,
  .bypass_mode, .power_ok_flag, .overvoltage_flag, .irq_n, .supply_fault_state);

// [verification/bdfc_host.sv]
// Host model: register port master and enable pin driver
module bdfc_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic external_enable_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    external_enable_pin = 1'b0;
  end
  // Released address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data is taken in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  task automatic scale(input logic [7:0] ctrl, input logic pin);
    wr(bdfc_pkg::REG_CTRL, ctrl);
    @(posedge mclk);
    external_enable_pin <= pin;
  endtask
endmodule

// [verification/buck_dvs_fault_control_test.sv]
// Self-checking bench for the buck scaling and fault control block
module buck_dvs_fault_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    bit w;
    logic [7:0] a;
    logic [7:0] d;
  } bdfc_row_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, external_enable_pin;
  logic mode_pin = 1'b0;
  logic uvlo_ok = 1'b0;
  logic [3:0] peak_at_limit = 4'h0;
  logic [3:0] peak_short = 4'h0;
  logic bypass_oc_detect = 1'b0;
  logic bypass_shutdown_detect = 1'b0;
  logic softstart_done = 1'b0;
  logic [3:0] rail_good_raw = 4'hF;
  logic [3:0] rail_overvolt_raw = 4'h0;
  logic [31:0] voltage_target;
  logic [3:0] rail_enable, high_side_on, low_side_enable;
  logic [3:0] power_ok_flag, overvoltage_flag, current_limit_flag;
  logic bypass_switch_on, bypass_mode, main_reset_out_n, irq_n, supply_fault_state;
  int n_mismatch = 0;
  int n_compared = 0;
  int n;
  // Register map rows: reads expect d, writes send d
  bdfc_row_t rows [22] = '{'{0, 8'h00, 8'h30}, '{0, 8'h01, 8'h00}, '{0, 8'h02, 8'h00},
    '{0, 8'h03, 8'h00}, '{0, 8'h04, 8'h00}, '{0, 8'h10, 8'h80}, '{0, 8'h13, 8'h80},
    '{0, 8'h14, 8'h60}, '{0, 8'h17, 8'h60}, '{0, 8'h18, 8'h80}, '{0, 8'h1B, 8'h80},
    '{0, 8'h06, 8'h00}, '{1, 8'h04, 8'h0F}, '{0, 8'h04, 8'h0F}, '{1, 8'h04, 8'h00},
    '{1, 8'h01, 8'hFF}, '{0, 8'h01, 8'h00}, '{1, 8'h1B, 8'h00}, '{0, 8'h1B, 8'h80},
    '{1, 8'h12, 8'h84}, '{0, 8'h12, 8'h84}, '{1, 8'h12, 8'h80}};

  // 20 MHz clock
  always #25 mclk = ~mclk;

  bdfc_host host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .external_enable_pin);

  // Short restart wait keeps the fault case brief
  bdfc_top #(.RESTART_CYCLES(4)) uut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .mode_pin, .uvlo_ok, .external_enable_pin, .peak_at_limit, .peak_short,
    .bypass_oc_detect, .bypass_shutdown_detect, .rail_good_raw, .rail_overvolt_raw,
    .softstart_done, .voltage_target, .rail_enable, .high_side_on, .low_side_enable,
    .bypass_switch_on, .bypass_mode, .power_ok_flag, .overvoltage_flag, .current_limit_flag,
    .main_reset_out_n, .irq_n, .supply_fault_state);

  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkr(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // A wait that runs out ends the run at once
  task tmo(input string nm);
    n_mismatch++;
    $display("Error %s expected event seen timeout", nm);
    print_verdict;
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk(nm, 32'(e), 32'(rv));
  endtask
  task wait_target(input logic [31:0] v, output int k);
    for (k = 0; k < 2000 && voltage_target !== v; k++) begin
      @(posedge mclk);
      #1;
    end
    if (k >= 2000) tmo("voltage target");
  endtask
  task wait_fault(input logic lvl, output int k);
    for (k = 0; k < 200 && supply_fault_state !== lvl; k++) begin
      @(posedge mclk);
      #1;
    end
    if (k >= 200) tmo("fault state");
  endtask
  // Cycles from a turn-on pulse of rail a to the next one of rail b
  task gap(input int a, input int b, output int k);
    int i;
    repeat (20) @(posedge mclk);
    #1;
    for (i = 0; i < 40 && high_side_on[a] !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    for (k = 0; k < 40 && ((k == 0 && a == b) || high_side_on[b] !== 1'b1); k++) begin
      @(posedge mclk);
      #1;
    end
    if (i >= 40 || k >= 40) tmo("turn-on pulse");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    uvlo_ok <= 1'b1;
    repeat (6) @(posedge mclk);
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      else rdchk("register", rows[i].a, rows[i].d);
    end
    repeat (100) @(posedge mclk);
    $display("test registers done");
    rail_overvolt_raw <= 4'hF;
    host.scale(8'h32, 1'b1);
    repeat (100) @(posedge mclk);
    #1 chk("overvolt hidden", 32'h0, 32'(overvoltage_flag));
    chk("main reset held", 32'h1, 32'(main_reset_out_n));
    wait_target(32'h6060_6060, n);
    chkr("ramp cycles", 258, 310, n + 100);
    repeat (4) @(posedge mclk);
    #1 chk("overvolt shown", 32'hF, 32'(overvoltage_flag));
    chk("main reset low", 32'h0, 32'(main_reset_out_n));
    host.scale(8'h32, 1'b0);
    wait_target(32'h8080_8080, n);
    host.scale(8'h37, 1'b0);
    wait_target(32'h6060_6060, n);
    chkr("slow ramp", 550, 580, n);
    host.scale(8'h30, 1'b0);
    wait_target(32'h8080_8080, n);
    $display("test scaling done");
    gap(2, 3, n);
    chkr("aligned gap", 0, 0, n);
    host.wr(8'h04, 8'h08);
    gap(2, 3, n);
    chkr("shifted gap", 2, 2, n);
    host.wr(8'h04, 8'h80);
    gap(2, 3, n);
    chkr("falling gap", 3, 6, n);
    host.wr(8'h04, 8'h00);
    gap(3, 3, n);
    chkr("full period", 8, 9, n);
    host.wr(8'h03, 8'h80);
    gap(3, 3, n);
    chkr("half period", 17, 18, n);
    host.wr(8'h03, 8'h00);
    $display("test switching done");
    // Broken run first: the count must start again
    @(posedge mclk);
    peak_at_limit <= 4'h2;
    repeat (100) @(posedge mclk);
    peak_at_limit <= 4'h0;
    repeat (20) @(posedge mclk);
    peak_at_limit <= 4'h2;
    for (n = 0; n < 400 && irq_n !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
    if (n >= 400) tmo("interrupt");
    chkr("run to interrupt", 120, 165, n);
    @(posedge mclk);
    peak_at_limit <= 4'h0;
    repeat (4) @(posedge mclk);
    rdchk("limit status", 8'h01, 8'h02);
    repeat (2) @(posedge mclk);
    #1 chk("interrupt released", 32'h1, 32'(irq_n));
    rdchk("limit status clear", 8'h01, 8'h00);
    host.wr(8'h03, 8'h01);
    @(posedge mclk);
    peak_at_limit <= 4'h1;
    peak_short <= 4'h1;
    repeat (200) @(posedge mclk);
    peak_at_limit <= 4'h0;
    peak_short <= 4'h0;
    repeat (4) @(posedge mclk);
    #1 chk("masked fault", 32'h0, 32'(supply_fault_state));
    chk("masked interrupt", 32'h1, 32'(irq_n));
    rdchk("masked status", 8'h01, 8'h00);
    host.wr(8'h03, 8'h00);
    @(posedge mclk);
    peak_short <= 4'h4;
    repeat (2) @(posedge mclk);
    peak_short <= 4'h0;
    wait_fault(1'b1, n);
    chk("rails off", 32'h0, 32'(rail_enable));
    wait_fault(1'b0, n);
    chkr("restart wait", 25, 49, n);
    rdchk("short status", 8'h01, 8'h04);
    $display("test faults done");
    // Second reset with the mode pin set, then moved
    @(posedge mclk);
    arst_n <= 1'b0;
    uvlo_ok <= 1'b0;
    mode_pin <= 1'b1;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    uvlo_ok <= 1'b1;
    repeat (8) @(posedge mclk);
    mode_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("bypass mode", 32'h1, 32'(bypass_mode));
    chk("good before soft start", 32'h0, 32'(power_ok_flag[0]));
    rdchk("bypass status", 8'h02, 8'h04);
    @(posedge mclk);
    softstart_done <= 1'b1;
    bypass_oc_detect <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk("bypass good", 32'h1, 32'(power_ok_flag[0]));
    chk("bypass overvolt", 32'h0, 32'(overvoltage_flag[0]));
    chk("bypass low side", 32'h0, 32'(low_side_enable[0]));
    chk("bypass limit", 32'h1, 32'(current_limit_flag[0]));
    @(posedge mclk);
    bypass_oc_detect <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk("bypass limit latch", 8'h01, 8'h01);
    host.wr(8'h00, 8'h70);
    @(posedge mclk);
    bypass_oc_detect <= 1'b1;
    repeat (10) @(posedge mclk);
    bypass_oc_detect <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk("bypass limit masked", 8'h01, 8'h00);
    host.wr(8'h00, 8'h30);
    @(posedge mclk);
    bypass_shutdown_detect <= 1'b1;
    repeat (2) @(posedge mclk);
    bypass_shutdown_detect <= 1'b0;
    wait_fault(1'b1, n);
    chk("switch off", 32'h0, 32'(bypass_switch_on));
    rdchk("undervolt latch", 8'h02, 8'h07);
    $display("test bypass done");
    print_verdict;
  end
endmodule
